// ---- rtl/usbrs_filt.sv ----
// line state qualifier: passes a state on after it held for the filter time
`include "usbrs_map.svh"
module usbrs_filt
	import usbrs_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [1:0] line_in,
	output logic [1:0] line_q
);
	localparam logic [9:0] FILT_LAST = 10'(`USBRS_FILT_CYC - 1);
	usbrs_flt_t st;
	usbrs_flt_t next_st;

	always_comb
	begin
		next_st = st;
		if (line_in != st.cur)
		begin
			next_st.cur = line_in;
			next_st.cnt = 10'h000;
		end
		else if (st.cnt != FILT_LAST)
			next_st.cnt = st.cnt + 10'h001;
		else
			next_st.qual = st.cur;
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			st <= '0;
		else if (ce)
			st <= next_st;
	end

	assign line_q = st.qual;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	a_filt_hold: assert property ($changed(line_q) |-> $past(st.cnt) == FILT_LAST)
		else $error("qualified line state changed before filter time");
	a_filt_value: assert property ($changed(line_q) |-> line_q == $past(st.cur))
		else $error("qualified line state differs from held state");
endmodule : usbrs_filt

// ---- rtl/usbrs_link.sv ----
// link-side suspend, resume and attach sequencer driving the transceiver controls
`include "usbrs_map.svh"
module usbrs_link
	import usbrs_pkg::*;
#(
	parameter logic [24:0] P_IDLE_CYC = 25'(`USBRS_IDLE_CYC),
	parameter logic [24:0] P_STAB_CYC = 25'(`USBRS_STAB_CYC),
	parameter logic [24:0] P_KMIN_CYC = 25'(`USBRS_KMIN_CYC),
	parameter logic [24:0] P_KMAX_CYC = 25'(`USBRS_KMAX_CYC),
	parameter logic [24:0] P_DEB_CYC = 25'(`USBRS_DEB_CYC)
)
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [3:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [31:0] wb_dat_w,
	output logic [31:0] wb_dat_r,
	output logic wb_ack,
	input wire logic vbus_valid,
	input wire logic [1:0] linestate,
	output logic suspendn,
	output logic [1:0] opmode,
	output logic termselect,
	output logic xcvrselect,
	output logic txvalid,
	output logic [7:0] data_out
);
	localparam int EOP_CYC = `USBRS_EOP_CYC;
	localparam logic [24:0] WAKE_LIM = 25'(`USBRS_WAKE_CYC);

	usbrs_st_t st;
	usbrs_st_t next_st;
	logic [1:0] line_q;
	logic [24:0] klen;
	logic [31:0] wmask;
	logic req;
	logic wr;
	logic sus_go;
	logic wake_go;

	// ****************************************
	// byte lane mask
	// ****************************************
	function automatic logic [31:0] usbrs_bmask(input logic [3:0] sel);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int i = 0; i < 4; i++)
			m[i * 8 +: 8] = {8{sel[i]}};
		return m;
	endfunction : usbrs_bmask

	// ****************************************
	// line state qualifier
	// ****************************************
	usbrs_filt u_filt (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.ce(ce),
		.line_in(linestate),
		.line_q(line_q)
	);

	// ****************************************
	// next state
	// ****************************************
	always_comb
	begin
		next_st = st;
		req = wb_cyc && wb_stb && !st.ack;
		wr = req && wb_we;
		wmask = usbrs_bmask(wb_sel);
		sus_go = 1'b0;
		wake_go = 1'b0;
		// resume K length clamped to its legal window
		if (st.ktime < P_KMIN_CYC)
			klen = P_KMIN_CYC;
		else if (st.ktime > P_KMAX_CYC)
			klen = P_KMAX_CYC;
		else
			klen = st.ktime;
		next_st.ack = req;
		next_st.dat_r = 32'h0000_0000;
		if (req && !wb_we)
		begin
			case (wb_adr)
				`USBRS_OFF_CTRL:
					next_st.dat_r = {29'h0000_0000, st.hs, st.rwake_en, st.attach_en};
				`USBRS_OFF_STAT:
					next_st.dat_r = {22'h00_0000, st.res_done, st.bus_rst, st.wake_pend,
						st.hs_was, line_q, st.fsm};
				`USBRS_OFF_KTIME:
					next_st.dat_r = {7'h00, st.ktime};
				default:
					next_st.dat_r = 32'h0000_0000;
			endcase
		end
		if (wr && wb_adr == `USBRS_OFF_CTRL && wb_sel[0])
		begin
			next_st.attach_en = wb_dat_w[`USBRS_CTRL_ATTACH];
			next_st.rwake_en = wb_dat_w[`USBRS_CTRL_RWAKE];
			next_st.hs = wb_dat_w[`USBRS_CTRL_HS];
			sus_go = wb_dat_w[`USBRS_CTRL_SUSP];
			wake_go = wb_dat_w[`USBRS_CTRL_WAKE];
		end
		if (wr && wb_adr == `USBRS_OFF_KTIME)
			next_st.ktime = (st.ktime & ~wmask[24:0]) | (wb_dat_w[24:0] & wmask[24:0]);
		// status clear comes first so a same-cycle set wins
		if (wr && wb_adr == `USBRS_OFF_STAT)
		begin
			if (wmask[`USBRS_STAT_BRST] && wb_dat_w[`USBRS_STAT_BRST])
				next_st.bus_rst = 1'b0;
			if (wmask[`USBRS_STAT_RES] && wb_dat_w[`USBRS_STAT_RES])
				next_st.res_done = 1'b0;
		end

		// continuous idle J time while suspended
		if ((st.fsm == USBRS_SUSP || st.fsm == USBRS_WAKE) && linestate == `USBRS_LS_J)
		begin
			if (st.idle != P_IDLE_CYC)
				next_st.idle = st.idle + 25'h000_0001;
		end
		else
			next_st.idle = 25'h000_0000;
		next_st.last_q = line_q;
		next_st.tmr = st.tmr + 25'h000_0001;

		unique case (st.fsm)
			USBRS_OFF:
			begin
				if (vbus_valid && st.attach_en)
				begin
					next_st.fsm = USBRS_DEB;
					next_st.tmr = 25'h000_0000;
				end
			end
			USBRS_DEB:
			begin
				if (st.tmr == P_DEB_CYC - 25'h000_0001)
				begin
					next_st.fsm = USBRS_RUN;
					if (linestate == `USBRS_LS_SE0)
					begin
						next_st.bus_rst = 1'b1;
						next_st.hs = 1'b0;
						next_st.wake_pend = 1'b0;
					end
				end
			end
			USBRS_RUN:
			begin
				if (sus_go)
				begin
					next_st.fsm = USBRS_SUSP;
					next_st.hs_was = st.hs;
					next_st.wake_pend = 1'b0;
				end
			end
			USBRS_SUSP:
			begin
				if (wake_go)
					next_st.wake_pend = 1'b1;
				if (st.last_q == `USBRS_LS_J && line_q == `USBRS_LS_K)
				begin
					next_st.fsm = USBRS_RXRES;
					next_st.wake_pend = 1'b0;
				end
				else if ((st.wake_pend || wake_go) && st.rwake_en && st.idle == P_IDLE_CYC)
				begin
					next_st.fsm = USBRS_WAKE;
					next_st.wake_pend = 1'b0;
					next_st.tmr = 25'h000_0000;
				end
			end
			USBRS_WAKE:
			begin
				if (st.tmr == P_STAB_CYC - 25'h000_0001)
				begin
					next_st.fsm = USBRS_DRVK;
					next_st.tmr = 25'h000_0000;
				end
			end
			USBRS_DRVK:
			begin
				// >= so a shorter ktime written during K still ends it
				if (st.tmr >= klen - 25'h000_0001)
					next_st.fsm = USBRS_WSE0;
			end
			USBRS_WSE0, USBRS_RXRES:
			begin
				if (linestate == `USBRS_LS_SE0)
				begin
					next_st.fsm = USBRS_RUN;
					next_st.hs = st.hs_was;
					next_st.res_done = 1'b1;
				end
			end
			default:
				next_st.fsm = USBRS_OFF;
		endcase
		if (!vbus_valid)
			next_st.fsm = USBRS_OFF;

		// transceiver controls follow the next state
		next_st.data = 8'h00;
		next_st.opmode = `USBRS_OPM_NORM;
		next_st.txvalid = 1'b0;
		next_st.suspendn = 1'b1;
		next_st.xcvr = 1'b1;
		next_st.term = 1'b1;
		unique case (next_st.fsm)
			USBRS_OFF:
				next_st.term = 1'b0;
			USBRS_RUN:
			begin
				next_st.xcvr = !next_st.hs;
				next_st.term = !next_st.hs;
			end
			USBRS_SUSP:
				next_st.suspendn = 1'b0;
			USBRS_DRVK:
			begin
				next_st.opmode = `USBRS_OPM_RAW;
				next_st.txvalid = 1'b1;
			end
			default:
				next_st.suspendn = 1'b1;
		endcase
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st <= '0;
			st.ktime <= 25'(`USBRS_KTIME_RST);
			st.suspendn <= 1'b1;
			st.xcvr <= 1'b1;
		end
		else if (ce)
			st <= next_st;
	end

	assign wb_dat_r = st.dat_r;
	assign wb_ack = st.ack;
	assign suspendn = st.suspendn;
	assign opmode = st.opmode;
	assign termselect = st.term;
	assign xcvrselect = st.xcvr;
	assign txvalid = st.txvalid;
	assign data_out = st.data;

	// ****************************************
	// checks
	// ****************************************
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	a_k_format: assert property (txvalid |-> opmode == `USBRS_OPM_RAW && data_out == 8'h00
		&& xcvrselect && termselect && suspendn)
		else $error("resume K driven with wrong controls");

	a_k_length: assert property ($fell(txvalid) && st.fsm == USBRS_WSE0
		|-> $past(st.tmr) >= P_KMIN_CYC - 25'h000_0001 && $past(st.tmr) < P_KMAX_CYC)
		else $error("resume K length outside 1 to 15 ms");

	a_idle_first: assert property ($rose(st.fsm == USBRS_WAKE) |-> $past(st.idle) == P_IDLE_CYC)
		else $error("remote wake started before 5 ms of idle");

	a_wake_limit: assert property (st.fsm == USBRS_WAKE |-> st.tmr < P_STAB_CYC && P_STAB_CYC < WAKE_LIM)
		else $error("wake to resume K exceeds its limit");

	a_jk_exit: assert property (ce && vbus_valid && st.fsm == USBRS_SUSP
		&& st.last_q == `USBRS_LS_J && line_q == `USBRS_LS_K |=> suspendn && st.fsm == USBRS_RXRES)
		else $error("suspend not left on J to K");

	a_se0_mode: assert property (ce && vbus_valid && linestate == `USBRS_LS_SE0
		&& (st.fsm == USBRS_WSE0 || st.fsm == USBRS_RXRES)
		|-> ##[1:EOP_CYC] st.fsm == USBRS_RUN && xcvrselect == !st.hs_was && termselect == !st.hs_was)
		else $error("speed mode not restored within 1.25 us of SE0");

	a_fs_terms: assert property (st.fsm == USBRS_RUN && !st.hs |-> xcvrselect && termselect)
		else $error("full-speed selects dropped after resume");

	a_attach_fs: assert property (st.fsm == USBRS_DEB |-> xcvrselect && termselect
		&& opmode == `USBRS_OPM_NORM && !txvalid)
		else $error("attach without full-speed selects");

	a_deb_len: assert property ($rose(st.fsm == USBRS_RUN) && $past(st.fsm) == USBRS_DEB
		|-> $past(st.tmr) == P_DEB_CYC - 25'h000_0001)
		else $error("debounce interval wrong length");

	a_bus_reset: assert property (ce && vbus_valid && st.fsm == USBRS_DEB
		&& st.tmr == P_DEB_CYC - 25'h000_0001 && linestate == `USBRS_LS_SE0
		|=> st.bus_rst && !st.hs && st.fsm == USBRS_RUN)
		else $error("SE0 after debounce not taken as bus reset");

	a_susp_low: assert property (st.fsm == USBRS_SUSP |-> !suspendn && !txvalid)
		else $error("suspend state without suspend control");

	a_ack_answer: assert property (ce && wb_cyc && wb_stb && !wb_ack |=> wb_ack)
		else $error("bus request not acknowledged in the next cycle");

	a_ack_pulse: assert property (ce && wb_ack |=> !wb_ack)
		else $error("bus acknowledge longer than one cycle");

	a_opmode_norm: assert property (!txvalid |-> opmode == `USBRS_OPM_NORM)
		else $error("raw operating mode without resume K");

	a_hs_selects: assert property (st.fsm == USBRS_RUN && st.hs
		|-> !xcvrselect && !termselect)
		else $error("high-speed selects missing in run");

	a_rx_awake: assert property (st.fsm == USBRS_RXRES |-> suspendn && !txvalid)
		else $error("suspend control low while resume is received");

	a_wake_awake: assert property (st.fsm == USBRS_WAKE |-> suspendn && !txvalid)
		else $error("suspend control low during wake start");

	a_k_bound: assert property (st.fsm == USBRS_DRVK |-> st.tmr < P_KMAX_CYC)
		else $error("resume K counter beyond its longest length");

	a_res_run: assert property ($rose(st.res_done) |-> st.fsm == USBRS_RUN)
		else $error("resume reported without return to run");

	a_vbus_off: assert property (ce && !vbus_valid
		|=> st.fsm == USBRS_OFF && !termselect && !txvalid)
		else $error("bus power loss did not detach");

	c_attach: cover property ($rose(st.fsm == USBRS_DEB));
	c_remote_wake: cover property ($fell(txvalid) && st.fsm == USBRS_WSE0);
	c_rx_resume: cover property ($rose(st.fsm == USBRS_RXRES));
	c_bus_reset: cover property ($rose(st.bus_rst));
	c_resume_done: cover property ($rose(st.res_done) && st.hs);
endmodule : usbrs_link

// ---- rtl/usbrs_map.svh ----
// timing counts, register map and reset values of the resume and attach sequencer
`ifndef USBRS_MAP_SVH
`define USBRS_MAP_SVH
// How it works
// - remote wake K starts only after the bus has idled J for 5 ms.
// - after a wake request, resume K starts well within 10 ms.
// - suspend is released at wake start or when incoming resume K begins.
// - resume K drives opmode 10, full-speed selects, txvalid and zero data.
// - a link suspended in full-speed keeps both selects high after resume.
// - resume K lasts at least 1 ms and at most 15 ms.
// - a link suspended in high-speed restores it within 1.25 us after SE0.
// - resume detection follows line state J, then K, then closing SE0.
// - suspend is left on the J to K transition, not on SE0.
// - within 1.25 us of SE0 the previous speed mode is restored.
// - full-speed resume keeps full-speed terminations enabled.
// - high-speed resume finishes its termination switch within 1.25 us.
// - at attach both selects go to full-speed, enabling the pull-up.
// - SE0 at debounce end is a bus reset; the link drops to full-speed and clears a pending wake.
// - attach follows bus power valid; debounce lasts at least 100 ms.
// - a bus state is qualified only after a continuous 2.5 us.
`define USBRS_CLK_KHZ 200000
`define USBRS_CLK_MHZ 200
`define USBRS_T_IDLE_MS 5
`define USBRS_IDLE_CYC (`USBRS_T_IDLE_MS * `USBRS_CLK_KHZ)
`define USBRS_T_WAKE_MS 10
`define USBRS_WAKE_CYC (`USBRS_T_WAKE_MS * `USBRS_CLK_KHZ)
`define USBRS_T_STAB_MS 2
`define USBRS_STAB_CYC (`USBRS_T_STAB_MS * `USBRS_CLK_KHZ)
`define USBRS_T_KMIN_MS 1
`define USBRS_KMIN_CYC (`USBRS_T_KMIN_MS * `USBRS_CLK_KHZ)
`define USBRS_T_KMAX_MS 15
`define USBRS_KMAX_CYC (`USBRS_T_KMAX_MS * `USBRS_CLK_KHZ)
`define USBRS_T_KDEF_MS 2
`define USBRS_KTIME_RST (`USBRS_T_KDEF_MS * `USBRS_CLK_KHZ)
`define USBRS_T_DEB_MS 100
`define USBRS_DEB_CYC (`USBRS_T_DEB_MS * `USBRS_CLK_KHZ)
`define USBRS_T_FILT_NS 2500
`define USBRS_FILT_CYC ((`USBRS_T_FILT_NS * `USBRS_CLK_MHZ + 999) / 1000)
`define USBRS_T_EOP_NS 1250
`define USBRS_EOP_CYC ((`USBRS_T_EOP_NS * `USBRS_CLK_MHZ) / 1000)
`define USBRS_OFF_CTRL 4'h0
`define USBRS_OFF_STAT 4'h4
`define USBRS_OFF_KTIME 4'h8
`define USBRS_CTRL_ATTACH 0
`define USBRS_CTRL_RWAKE 1
`define USBRS_CTRL_HS 2
`define USBRS_CTRL_SUSP 3
`define USBRS_CTRL_WAKE 4
`define USBRS_STAT_BRST 8
`define USBRS_STAT_RES 9
`define USBRS_LS_SE0 2'h0
`define USBRS_LS_J 2'h1
`define USBRS_LS_K 2'h2
`define USBRS_OPM_NORM 2'h0
`define USBRS_OPM_RAW 2'h2
`endif

// ---- rtl/usbrs_pkg.sv ----
// types of the resume and attach sequencer
`include "usbrs_map.svh"
package usbrs_pkg;
	typedef enum logic [3:0] {
		USBRS_OFF = 4'h0,
		USBRS_DEB = 4'h1,
		USBRS_RUN = 4'h2,
		USBRS_SUSP = 4'h3,
		USBRS_WAKE = 4'h4,
		USBRS_DRVK = 4'h5,
		USBRS_WSE0 = 4'h6,
		USBRS_RXRES = 4'h7
	} usbrs_fsm_t;

	typedef struct packed {
		usbrs_fsm_t fsm;
		logic [24:0] tmr;
		logic [24:0] idle;
		logic [24:0] ktime;
		logic [1:0] last_q;
		logic attach_en;
		logic rwake_en;
		logic hs;
		logic hs_was;
		logic wake_pend;
		logic bus_rst;
		logic res_done;
		logic ack;
		logic [31:0] dat_r;
		logic suspendn;
		logic [1:0] opmode;
		logic xcvr;
		logic term;
		logic txvalid;
		logic [7:0] data;
	} usbrs_st_t;

	typedef struct packed {
		logic [1:0] cur;
		logic [9:0] cnt;
		logic [1:0] qual;
	} usbrs_flt_t;
endpackage : usbrs_pkg

// ---- tb/tb_top.sv ----
// testbench of the resume and attach sequencer
`include "usbrs_map.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import usbrs_pkg::*;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic ce = 1'b1;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [3:0] wb_adr = 4'h0;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_dat_w = 32'h0;
	logic [31:0] wb_dat_r;
	logic wb_ack;
	logic vbus_valid = 1'b0;
	logic [1:0] host_ls = 2'h1;
	logic [1:0] linestate;
	logic suspendn, termselect, xcvrselect, txvalid;
	logic [1:0] opmode;
	logic [7:0] data_out;
	logic [31:0] q;
	int error_cnt = 0;
	int compares = 0;
	int cyc_cnt = 0;
	int n;
	always #2.5 sys_clk = ~sys_clk;
	// shortened interval counts
	usbrs_link #(.P_IDLE_CYC(25'h000_0014), .P_STAB_CYC(25'h000_000A),
		.P_KMIN_CYC(25'h000_0008), .P_KMAX_CYC(25'h000_0028),
		.P_DEB_CYC(25'h000_001E)) uut (.sys_clk(sys_clk), .rstn(rstn),
		.ce(ce), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
		.wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
		.vbus_valid(vbus_valid), .linestate(linestate), .suspendn(suspendn),
		.opmode(opmode), .termselect(termselect), .xcvrselect(xcvrselect),
		.txvalid(txvalid), .data_out(data_out));
	usbrs_xcvr xcvr (.suspendn(suspendn), .opmode(opmode), .termselect(termselect),
		.xcvrselect(xcvrselect), .txvalid(txvalid), .data_out(data_out),
		.host_ls(host_ls), .linestate(linestate));
	// ****************************************
	// tasks
	// ****************************************
	task end_of_test;
		$display("comparisons %0d, mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		compares++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : chk
	task t_end(input string nm);
		$display("test %s finished, mismatches %0d", nm, error_cnt);
	endtask : t_end
	task wb_xfer(input logic we, input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_sel <= 4'hF;
		wb_dat_w <= d;
		do
			@(posedge sys_clk);
		while (wb_ack !== 1'b1);
		q = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask : wb_xfer
	task wait_cyc(input int c);
		repeat (c) @(posedge sys_clk);
	endtask : wait_cyc
	always @(posedge sys_clk)
	begin
		cyc_cnt++;
		if (cyc_cnt == 20000)
		begin
			error_cnt++;
			end_of_test();
		end
	end
	// ****************************************
	// sequence
	// ****************************************
	initial
	begin
		wait_cyc(2);
		rstn <= 1'b1;
		@(posedge sys_clk);
		chk({suspendn, opmode, termselect, xcvrselect, txvalid, data_out},
			{1'b1, 2'h0, 1'b0, 1'b1, 1'b0, 8'h00}, "reset pins");
		wb_xfer(1'b0, 4'h8, 32'h0);
		chk(q, 32'h00061A80, "ktime reset");
		wb_xfer(1'b0, 4'hC, 32'h0);
		chk(q, 32'h0, "unmapped read");
		t_end("reset");
		vbus_valid <= 1'b1;
		host_ls <= `USBRS_LS_SE0;
		wb_xfer(1'b1, 4'h0, 32'h3);
		wait_cyc(3);
		chk({termselect, xcvrselect}, 2'b11, "attach selects");
		wait_cyc(15);
		wb_xfer(1'b0, 4'h4, 32'h0);
		chk(q[3:0], 4'h1, "still debouncing");
		wait_cyc(20);
		wb_xfer(1'b0, 4'h4, 32'h0);
		chk({q[8], q[3:0]}, 5'h12, "bus reset at debounce end");
		wb_xfer(1'b1, 4'h4, 32'h100);
		host_ls <= `USBRS_LS_J;
		t_end("attach");
		wb_xfer(1'b1, 4'h8, 32'h8);
		wait_cyc(520);
		wb_xfer(1'b1, 4'h0, 32'hB);
		wait_cyc(2);
		chk(suspendn, 1'b0, "suspended");
		wb_xfer(1'b1, 4'h0, 32'h13);
		for (n = 0; n < 200 && txvalid !== 1'b1; n++)
			@(posedge sys_clk);
		chk(32'(n >= 10 && n < 200), 32'h1, "wake delay");
		chk(suspendn, 1'b1, "awake before K");
		chk({opmode, data_out, termselect, xcvrselect}, {2'h2, 8'h00, 2'b11}, "K drive");
		host_ls <= `USBRS_LS_K;
		for (n = 0; n < 100 && txvalid === 1'b1; n++)
			@(posedge sys_clk);
		chk(n, 8, "K length");
		host_ls <= `USBRS_LS_SE0;
		wait_cyc(2);
		chk({termselect, xcvrselect}, 2'b11, "full-speed restore");
		host_ls <= `USBRS_LS_J;
		wb_xfer(1'b0, 4'h4, 32'h0);
		chk({q[9], q[3:0]}, 5'h12, "resume done");
		wb_xfer(1'b1, 4'h4, 32'h200);
		t_end("remote wake");
		wb_xfer(1'b1, 4'h0, 32'h7);
		wait_cyc(10);
		wb_xfer(1'b1, 4'h0, 32'hF);
		wait_cyc(3);
		chk({suspendn, termselect, xcvrselect}, 3'b011, "suspend selects");
		host_ls <= `USBRS_LS_K;
		for (n = 0; n < 700 && suspendn !== 1'b1; n++)
			@(posedge sys_clk);
		chk(32'(n >= 500 && n < 600), 32'h1, "leave suspend on K");
		host_ls <= `USBRS_LS_SE0;
		wait_cyc(2);
		chk({termselect, xcvrselect}, 2'b00, "high-speed restore");
		host_ls <= `USBRS_LS_J;
		wb_xfer(1'b0, 4'h4, 32'h0);
		chk({q[9], q[3:0]}, 5'h12, "resume done");
		t_end("resume detect");
		ce <= 1'b0;
		vbus_valid <= 1'b0;
		wait_cyc(3);
		chk({termselect, xcvrselect}, 2'b00, "frozen while disabled");
		ce <= 1'b1;
		wait_cyc(2);
		chk({termselect, xcvrselect}, 2'b01, "detach");
		t_end("detach");
		end_of_test();
	end
endmodule : tb_top

// ---- tb/usbrs_xcvr.sv ----
// transceiver model: line state as the link sees it
`include "usbrs_map.svh"
module usbrs_xcvr
	import usbrs_pkg::*;
(
	input wire logic suspendn,
	input wire logic [1:0] opmode,
	input wire logic termselect,
	input wire logic xcvrselect,
	input wire logic txvalid,
	input wire logic [7:0] data_out,
	input wire logic [1:0] host_ls,
	output logic [1:0] linestate
);
	timeunit 1ns;
	timeprecision 1ps;
	always_comb
	begin
		// raw zero data with full-speed selects puts K on the bus
		if (suspendn && txvalid && opmode == `USBRS_OPM_RAW && data_out == 8'h00
			&& termselect && xcvrselect)
			linestate = `USBRS_LS_K;
		else
			linestate = host_ls;
	end
endmodule : usbrs_xcvr
